// [design/serial_mp_consts.svh]
// register map, field positions, reset values and timing for the serial unit
// Operation
// [RQ1] multiprocessor frames carry an extra bit: 1 marks ID, 0 marks data
// [RQ2] sender transmits target ID with bit set, then data with bit cleared
// [RQ3] ID frame compared to own ID; match accepts data, mismatch skips it
// [RQ4] multiprocessor format ignores parity setting; no parity made or checked
// [RQ5] empty flag 0: holding word moves to shifter, flag set, frame starts
// [RQ6] stop bit tests empty flag: send next word, or set end flag, idle high
// [RQ7] six sources: transmit end, empty, receive full, overrun, framing, parity
// [RQ8] empty request follows empty flag, end request follows end flag, enabled
// [RQ9] empty and end flags reset to 1, so enabled requests fire at once
// [RQ10] full request follows full flag; error request follows any error flag
// [RQ11] transmit requests gated by transmit enable; receive ones by receive enable; code uses tx_empty_irq_en, tx_end_irq_en, rx_irq_en, not txe/rxe
// [RQ12] holding write clears empty flag; transfer into shifter sets it again
// [RQ13] holding writes always accepted; a pending unsent word is overwritten
// [RQ14] software writes each word once, only after seeing empty flag set
// [RQ15] overrun sets its flag, full stays 1, received word is discarded
// [RQ16] framing or parity alone set their flags; word still copied, full kept
// [RQ17] to go full duplex from transmit: wait both flags, clear, set both enables
// [RQ18] to go full duplex from receive: stop, check flags clear, set both enables
// [RQ19] reception halts while any error flag is set until software clears them
// [RQ20] reading received word clears full flag; frame ending with full set overruns
// [RQ21] receiver oversamples 16x, syncs on start edge, samples at eighth pulse
// [RQ22] while skipping, data frames change no flag and raise no request
`ifndef SERIAL_MP_CONSTS_SVH
`define SERIAL_MP_CONSTS_SVH
`define OFF_CTRL   8'h00
`define OFF_STAT   8'h04
`define OFF_TXDATA 8'h08
`define OFF_RXDATA 8'h0c
`define OFF_BAUD   8'h10
`define OFF_OWNID  8'h14
`define C_TXE  0
`define C_RXE  1
`define C_TIE  2
`define C_RIE  3
`define C_TX_END_IRQ_EN 4
`define C_MP   5
`define C_PEN  6
`define C_PODD 7
`define S_TBE  0
`define S_TX_END_FLAG 1
`define S_RFUL 2
`define S_OER  3
`define S_FER  4
`define S_PER  5
`define BAUD_RST  16'h0035
`define OVS_LAST  4'hf
`define SAMPLE_AT 4'h7
`define BITS_PLAIN 4'ha
`define BITS_EXTRA 4'hb
`endif

// [design/serial_mp_pkg.sv]
// types for the serial unit
package serial_mp_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_st_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_st_e;
  typedef struct packed {
    tx_st_e      st;
    logic [3:0]  cnt;
    logic [3:0]  left;
    logic [10:0] sh;
    logic        txd;
    logic        done;
  } tx_s;
  typedef struct packed {
    rx_st_e     st;
    logic [3:0] cnt;
    logic [3:0] idx;
    logic [9:0] sh;
    logic       prev;
    logic       done;
  } rx_s;
  typedef struct packed {
    logic txe, rxe, tx_empty_irq_en, rx_irq_en, tx_end_irq_en, mp, pen, podd;
    logic tbe, tx_end_flag, rfull, overrun_flag, framing_flag, per;
    logic [8:0]  thold;
    logic [8:0]  tnext;
    logic        queued;
    logic [8:0]  rhold;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic        tick;
    logic [7:0]  myid;
    logic        listen;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        tx_load;
    logic [8:0]  tx_data;
    logic        irq_txe, irq_tx_end_flag, irq_rxf, irq_err;
  } main_s;
endpackage

// [design/serial_tx_shift.sv]
// transmit shifter: start, 8 data, optional extra bit, stop
`timescale 1ns/1ps
`default_nettype none
`include "serial_mp_consts.svh"
module serial_tx_shift (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [8:0] data,
  input  wire logic       use_extra,
  output logic            txd,
  output logic            busy,
  output logic            in_stop,
  output logic            done
);
  serial_mp_pkg::tx_s s;
  serial_mp_pkg::tx_s n;

  always_comb begin
    n = s;
    n.done = 1'b0;
    case (s.st)
      serial_mp_pkg::TX_IDLE: begin
        if (load) begin
          n.st = serial_mp_pkg::TX_SHIFT;
          n.sh = use_extra ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
          n.left = use_extra ? `BITS_EXTRA : `BITS_PLAIN;
          n.cnt = 4'h0;
          n.txd = 1'b0;
        end
      end
      serial_mp_pkg::TX_SHIFT: begin
        if (tick) begin
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == `OVS_LAST) begin
            if (s.left == 4'h1) begin
              n.st = serial_mp_pkg::TX_IDLE;
              n.done = 1'b1;
              n.txd = 1'b1;
            end else begin
              n.sh = {1'b1, s.sh[10:1]};
              n.txd = s.sh[1];
              n.left = s.left - 4'h1;
            end
          end
        end
      end
      default: n.st = serial_mp_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.txd <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign txd = s.txd;
  assign busy = (s.st == serial_mp_pkg::TX_SHIFT);
  assign in_stop = busy && (s.left == 4'h1);
  assign done = s.done;
endmodule // serial_tx_shift
`default_nettype wire

// [design/serial_rx_sample.sv]
// receive sampler on the 16x tick
`timescale 1ns/1ps
`default_nettype none
`include "serial_mp_consts.svh"
module serial_rx_sample (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       en,
  input  wire logic       rxd,
  input  wire logic       use_extra,
  output logic            done,
  output logic [7:0]      data,
  output logic            extra,
  output logic            stop_ok
);
  serial_mp_pkg::rx_s s;
  serial_mp_pkg::rx_s n;
  logic [3:0] nbits;

  always_comb begin
    n = s;
    n.done = 1'b0;
    nbits = use_extra ? `BITS_PLAIN - 4'h1 : `BITS_PLAIN - 4'h2;
    if (tick) begin
      n.prev = rxd;
      n.cnt = s.cnt + 4'h1;
    end
    case (s.st)
      serial_mp_pkg::RX_IDLE: begin
        if (tick && s.prev && !rxd) begin
          n.st = serial_mp_pkg::RX_START;
          n.cnt = 4'h0;
        end
      end
      serial_mp_pkg::RX_START: begin
        if (tick && s.cnt == `SAMPLE_AT - 4'h1) begin
          n.cnt = 4'h0;
          n.idx = 4'h0;
          n.st = rxd ? serial_mp_pkg::RX_IDLE : serial_mp_pkg::RX_BITS; // RQ21
        end
      end
      serial_mp_pkg::RX_BITS: begin
        if (tick && s.cnt == `OVS_LAST) begin
          n.sh[s.idx] = rxd; // RQ21
          n.idx = s.idx + 4'h1;
          if (s.idx == nbits) begin
            n.st = serial_mp_pkg::RX_IDLE;
            n.done = 1'b1;
          end
        end
      end
      default: n.st = serial_mp_pkg::RX_IDLE;
    endcase
    if (!en) begin
      n.st = serial_mp_pkg::RX_IDLE;
      n.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.prev <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign done = s.done;
  assign data = s.sh[7:0];
  assign extra = use_extra ? s.sh[8] : 1'b0;
  assign stop_ok = use_extra ? s.sh[9] : s.sh[8];
endmodule // serial_rx_sample
`default_nettype wire

// [design/serial_mp_unit.sv]
// serial unit top: apb registers, transmit and receive control, requests
`timescale 1ns/1ps
`default_nettype none
`include "serial_mp_consts.svh"
module serial_mp_unit #(
  parameter logic [15:0] BAUD_RESET = `BAUD_RST
) (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             TX_EMPTY_IRQ,
  output logic             TX_END_IRQ,
  output logic             RX_FULL_IRQ,
  output logic             RX_ERROR_IRQ
);

  // ***********************************************
  // elaboration check
  // ***********************************************
  if (BAUD_RESET == 16'h0000) begin : g_chk
    $error("baud divisor must be at least one");
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, `OFF_CTRL) || hit(a, `OFF_STAT) || hit(a, `OFF_TXDATA) ||
           hit(a, `OFF_RXDATA) || hit(a, `OFF_BAUD) || hit(a, `OFF_OWNID);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // ***********************************************
  // state
  // ***********************************************
  serial_mp_pkg::main_s s;
  serial_mp_pkg::main_s n;

  logic        setup;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        rd_rx;
  logic        rfull_eff;
  logic        use_extra;
  logic        rx_en;
  logic        rx_perr;
  logic        tx_busy;
  logic        tx_stop;
  logic        tx_done;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_extra;
  logic        rx_stop;
  logic [31:0] rdata;

  assign use_extra = s.mp || s.pen;
  assign rx_en = s.rxe && !(s.overrun_flag || s.framing_flag || s.per); // RQ19
  assign rx_perr = s.pen && !s.mp && (rx_extra != par_bit(rx_data, s.podd)); // RQ4

  // ***********************************************
  // read mux
  // ***********************************************
  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR)
      `OFF_CTRL: begin
        rdata[`C_TXE] = s.txe;
        rdata[`C_RXE] = s.rxe;
        rdata[`C_TIE] = s.tx_empty_irq_en;
        rdata[`C_RIE] = s.rx_irq_en;
        rdata[`C_TX_END_IRQ_EN] = s.tx_end_irq_en;
        rdata[`C_MP] = s.mp;
        rdata[`C_PEN] = s.pen;
        rdata[`C_PODD] = s.podd;
      end
      `OFF_STAT: begin
        rdata[`S_TBE] = s.tbe;
        rdata[`S_TX_END_FLAG] = s.tx_end_flag;
        rdata[`S_RFUL] = s.rfull;
        rdata[`S_OER] = s.overrun_flag;
        rdata[`S_FER] = s.framing_flag;
        rdata[`S_PER] = s.per;
      end
      `OFF_TXDATA: rdata[8:0] = s.thold;
      `OFF_RXDATA: rdata[8:0] = s.rhold;
      `OFF_BAUD:   rdata[15:0] = s.div;
      `OFF_OWNID:  rdata[7:0] = s.myid;
      default:     rdata = 32'h0000_0000;
    endcase
  end

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.tx_load = 1'b0;
    setup = PSEL && !PENABLE && !s.pready;
    acc = PSEL && PENABLE && s.pready;
    wr = acc && PWRITE;
    rd = acc && !PWRITE;
    rd_rx = rd && hit(PADDR, `OFF_RXDATA);
    rfull_eff = s.rfull && !rd_rx;

    // 16x tick divider
    if (s.bcnt >= s.div) begin
      n.bcnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.bcnt = s.bcnt + 16'h0001;
    end

    // bus handshake, one access cycle
    if (setup) begin
      n.pready = 1'b1;
      n.pslverr = !mapped(PADDR);
      n.prdata = rdata;
    end else if (acc) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end

    // register writes
    if (wr && hit(PADDR, `OFF_CTRL)) begin
      n.txe = PWDATA[`C_TXE];
      n.rxe = PWDATA[`C_RXE];
      n.tx_empty_irq_en = PWDATA[`C_TIE];
      n.rx_irq_en = PWDATA[`C_RIE];
      n.tx_end_irq_en = PWDATA[`C_TX_END_IRQ_EN];
      n.mp = PWDATA[`C_MP];
      n.pen = PWDATA[`C_PEN];
      n.podd = PWDATA[`C_PODD];
    end
    if (wr && hit(PADDR, `OFF_BAUD)) begin
      n.div = (PWDATA[15:0] == 16'h0000) ? 16'h0001 : PWDATA[15:0];
    end
    if (wr && hit(PADDR, `OFF_OWNID)) begin
      n.myid = PWDATA[7:0];
    end
    // writing 0 clears a receive flag; events below set it again
    if (wr && hit(PADDR, `OFF_STAT)) begin
      if (!PWDATA[`S_RFUL]) n.rfull = 1'b0;
      if (!PWDATA[`S_OER]) n.overrun_flag = 1'b0;
      if (!PWDATA[`S_FER]) n.framing_flag = 1'b0;
      if (!PWDATA[`S_PER]) n.per = 1'b0;
    end
    if (rd_rx) begin
      n.rfull = 1'b0; // RQ20
    end

    // ***********************************************
    // transmit control
    // ***********************************************
    if (tx_done) begin
      if (s.queued) begin
        n.tx_load = 1'b1;
        n.tx_data = s.tnext;
        n.queued = 1'b0;
      end else begin
        n.tx_end_flag = 1'b1; // RQ6
      end
    end else if (s.txe && !s.tbe && !tx_busy && !s.tx_load && !s.queued) begin
      n.tx_load = 1'b1; // RQ5
      n.tx_data = {s.mp ? s.thold[8] : par_bit(s.thold[7:0], s.podd), s.thold[7:0]};
      n.tbe = 1'b1; // RQ12
      n.tx_end_flag = 1'b0;
    end
    // stop bit test: hand the next word over early
    if (tx_stop && !tx_done && s.txe && !s.tbe && !s.queued) begin
      n.tnext = {s.mp ? s.thold[8] : par_bit(s.thold[7:0], s.podd), s.thold[7:0]}; // RQ1
      n.queued = 1'b1; // RQ6
      n.tbe = 1'b1; // RQ12
    end
    if (!s.txe) begin
      n.tbe = 1'b1;
    end
    // a write always lands, even over an unsent word
    if (wr && hit(PADDR, `OFF_TXDATA)) begin
      n.thold = PWDATA[8:0]; // RQ13
      n.tbe = 1'b0; // RQ12
    end

    // ***********************************************
    // receive control
    // ***********************************************
    if (rx_done) begin
      if (s.mp && rx_extra) begin
        n.listen = (rx_data == s.myid); // RQ3
      end else if (!s.mp || s.listen) begin // RQ22
        if (!rx_stop) n.framing_flag = 1'b1; // RQ16
        if (rx_perr) n.per = 1'b1; // RQ16
        if (rfull_eff) begin
          n.overrun_flag = 1'b1; // RQ15
        end else begin
          n.rhold = {rx_extra, rx_data}; // RQ16
          if (rx_stop && !rx_perr) n.rfull = 1'b1;
        end
      end
    end

    // ***********************************************
    // requests follow flags and enables
    // ***********************************************
    n.irq_txe = n.tbe && n.tx_empty_irq_en; // RQ8 RQ11
    n.irq_tx_end_flag = n.tx_end_flag && n.tx_end_irq_en; // RQ8
    n.irq_rxf = n.rfull && n.rx_irq_en; // RQ10 RQ11
    n.irq_err = (n.overrun_flag || n.framing_flag || n.per) && n.rx_irq_en; // RQ7 RQ10
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '0;
      s.tbe <= 1'b1; // RQ9
      s.tx_end_flag <= 1'b1; // RQ9
      s.div <= BAUD_RESET;
    end else if (CE) begin
      s <= n;
    end
  end

  // ***********************************************
  // shifters
  // ***********************************************
  serial_tx_shift u_tx (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .ce        (CE),
    .tick      (s.tick),
    .load      (s.tx_load),
    .data      (s.tx_data),
    .use_extra (use_extra),
    .txd       (TXD),
    .busy      (tx_busy),
    .in_stop   (tx_stop),
    .done      (tx_done)
  );

  serial_rx_sample u_rx (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .ce        (CE),
    .tick      (s.tick),
    .en        (rx_en),
    .rxd       (RXD),
    .use_extra (use_extra),
    .done      (rx_done),
    .data      (rx_data),
    .extra     (rx_extra),
    .stop_ok   (rx_stop)
  );

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign TX_EMPTY_IRQ = s.irq_txe;
  assign TX_END_IRQ = s.irq_tx_end_flag;
  assign RX_FULL_IRQ = s.irq_rxf;
  assign RX_ERROR_IRQ = s.irq_err;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  sequence tx_written;
    CE && wr && hit(PADDR, `OFF_TXDATA);
  endsequence

  sequence tx_handed;
    CE && s.tx_load ##1 CE && tx_busy;
  endsequence

  txe_irq_a: assert property ( // RQ8
    TX_EMPTY_IRQ == (s.tbe && s.tx_empty_irq_en))
    else $error("empty request does not follow flag");

  txwr_clr_a: assert property ( // RQ12
    tx_written |=> !s.tbe)
    else $error("holding write did not clear empty flag");

  txload_a: assert property ( // RQ5
    CE && s.txe && !s.tbe && !tx_busy && !s.tx_load && !s.queued && !tx_done |=> tx_handed)
    else $error("written word did not start a frame");

  txset_a: assert property ( // RQ12
    CE && s.txe && !s.tbe && !tx_busy && !s.tx_load && !s.queued && !tx_done &&
    !(wr && hit(PADDR, `OFF_TXDATA)) |=> s.tbe)
    else $error("hand-over did not set empty flag");

  txend_a: assert property ( // RQ6
    CE && tx_done && !s.queued |=> s.tx_end_flag && TXD)
    else $error("end flag not set after last stop bit");

  txchain_a: assert property ( // RQ6
    CE && tx_done && s.queued |=> tx_handed)
    else $error("queued word not sent after stop bit");

  ovr_keep_a: assert property ( // RQ15
    CE && rx_done && rfull_eff && (!s.mp || (!rx_extra && s.listen))
    |=> s.overrun_flag && s.rfull && $stable(s.rhold))
    else $error("overrun did not keep old word");

  ferr_copy_a: assert property ( // RQ16
    CE && rx_done && !rfull_eff && !rx_stop && !s.mp
    |=> s.framing_flag && !s.rfull && s.rhold[7:0] == $past(rx_data))
    else $error("framing error word not copied");

  rdclr_a: assert property ( // RQ20
    CE && rd_rx && !rx_done |=> !s.rfull)
    else $error("read did not clear full flag");

  errhalt_a: assert property ( // RQ19
    (s.overrun_flag || s.framing_flag || s.per) |-> !rx_en ##1 !rx_done)
    else $error("reception went on with error flag set");

  mpskip_a: assert property ( // RQ3
    CE && rx_done && s.mp && rx_extra && rx_data != s.myid
    |=> !s.listen)
    else $error("mismatched id did not start skipping");

  par_ign_a: assert property ( // RQ4
    CE && rx_done && s.mp |=> !s.per)
    else $error("parity checked in multiprocessor format");

  skip_quiet_a: assert property ( // RQ22
    CE && rx_done && s.mp && !rx_extra && !s.listen
    |=> !$rose(s.rfull) && !s.overrun_flag && !s.framing_flag && $stable(s.rhold))
    else $error("skipped data frame changed receive state");

endmodule // serial_mp_unit
`default_nettype wire

// [verif/serial_peer.sv]
// far-side station model on the shared serial line
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [8:0] got_q[$];
  logic       extra_on;
  logic [8:0] w;

  initial begin
    line_out = 1'b1;
    extra_on = 1'b1;
  end

  // ***************************************
  // frame out: start, data lsb first, extra, stop
  // ***************************************
  task automatic send(input logic [7:0] d, input logic x, input logic stop);
    logic [10:0] f;
    f = {stop, x, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || extra_on) begin
        @(posedge clk);
        line_out <= f[i];
        repeat (BIT_CYC - 1) @(posedge clk);
      end
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask

  // frame in: sampled mid-bit, kept only with a good stop bit
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk);
      w = 9'h0;
      for (int i = 0; i < 9; i++) begin
        if (i < 8 || extra_on) begin
          repeat (BIT_CYC) @(posedge clk);
          w[i] = line_in;
        end
      end
      repeat (BIT_CYC) @(posedge clk);
      if (line_in === 1'b1) got_q.push_back(w);
    end
  end
endmodule // serial_peer
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "serial_mp_consts.svh"
module tb_top;
  localparam int BAUD_D  = 1;
  localparam int BIT_CYC = 16 * (BAUD_D + 1);
  logic        mclk, reset_n, psel, penable, pwrite, rxd, txd;
  logic        pready, pslverr, rerr, irq_te, irq_tn, irq_rf, irq_re;
  logic [7:0]  paddr, own, d0, d1, d2, d3;
  logic [31:0] pwdata, prdata, rdat, seed;
  int          err_count, cmp_count, cyc, n;

  serial_mp_unit i_dut (
    .MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .TXD(txd),
    .TX_EMPTY_IRQ(irq_te), .TX_END_IRQ(irq_tn), .RX_FULL_IRQ(irq_rf),
    .RX_ERROR_IRQ(irq_re)
  );
  serial_peer #(.BIT_CYC(BIT_CYC)) i_peer (.clk(mclk), .line_in(txd), .line_out(rxd));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ***************************************
  // bus, compare and expectation helpers
  // ***************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  task automatic irq(input logic [3:0] e);
    @(negedge mclk);
    chk("irq", {28'h0, e}, {28'h0, irq_te, irq_tn, irq_rf, irq_re});
  endtask

  task automatic wait_stat(input logic [31:0] m);
    for (n = 0; n < 2000; n++) begin
      apb(1'b0, `OFF_STAT, 32'h0);
      if ((rdat & m) === m) break;
    end
    chk("stat wait", m, rdat & m);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic rnd(output logic [7:0] v);
    repeat (8) seed = lfsr(seed);
    v = seed[7:0];
  endtask

  function automatic logic [31:0] stat(input logic f, o, fr, p);
    return {26'h0, p, fr, o, f, 2'b11};
  endfunction

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'he6c8;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rchk("ctrl", `OFF_CTRL, 32'h0);
    rchk("stat", `OFF_STAT, stat(0, 0, 0, 0));
    rchk("baud", `OFF_BAUD, 32'h35);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped", 32'h0, rdat);
    apb(1'b1, `OFF_BAUD, BAUD_D);
    apb(1'b1, `OFF_CTRL, 32'h14);
    irq(4'b1100);
    rnd(d0);
    rnd(d1);
    rnd(d2);
    d2 = (d2 == d1) ? ~d1 : d2;
    apb(1'b1, `OFF_CTRL, 32'h75);
    apb(1'b1, `OFF_TXDATA, {23'h0, 1'b1, d0});
    wait_stat(32'h1);
    apb(1'b1, `OFF_TXDATA, {24'h0, d1});
    apb(1'b1, `OFF_TXDATA, {24'h0, d2});
    irq(4'b0000);
    for (n = 0; n < 3000 && i_peer.got_q.size() < 2; n++) @(posedge mclk);
    chk("tx count", 32'h2, i_peer.got_q.size());
    chk("tx id", {23'h0, 1'b1, d0}, {23'h0, i_peer.got_q[0]});
    chk("tx data", {24'h0, d2}, {23'h0, i_peer.got_q[1]});
    wait_stat(32'h3);
    irq(4'b1100);
    chk("tx idle", 32'h1, {31'h0, txd});
    apb(1'b1, `OFF_CTRL, 32'h74);
    apb(1'b1, `OFF_CTRL, 32'h77);
    irq(4'b1100);
    rnd(own);
    apb(1'b1, `OFF_OWNID, {24'h0, own});
    apb(1'b1, `OFF_CTRL, 32'h6a);
    i_peer.send(d0, 1'b0, 1'b1);
    i_peer.send(own ^ 8'h01, 1'b1, 1'b1);
    i_peer.send(d1, 1'b0, 1'b1);
    rchk("skip", `OFF_STAT, stat(0, 0, 0, 0));
    irq(4'b0000);
    rnd(d2);
    d2[7] = ~^d2[6:0];
    i_peer.send(own, 1'b1, 1'b1);
    i_peer.send(d2, 1'b0, 1'b1);
    rchk("full", `OFF_STAT, stat(1, 0, 0, 0));
    irq(4'b0010);
    rchk("rxdata", `OFF_RXDATA, {24'h0, d2});
    rchk("read clr", `OFF_STAT, stat(0, 0, 0, 0));
    rnd(d3);
    i_peer.send(d3, 1'b0, 1'b1);
    i_peer.send(d1, 1'b0, 1'b1);
    rchk("overrun", `OFF_STAT, stat(1, 1, 0, 0));
    irq(4'b0011);
    rchk("ovr data", `OFF_RXDATA, {24'h0, d3});
    i_peer.send(d0, 1'b0, 1'b1);
    rchk("halted", `OFF_STAT, stat(0, 1, 0, 0));
    apb(1'b1, `OFF_STAT, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h4a);
    i_peer.send(d1, ~^d1, 1'b0);
    rchk("fer per", `OFF_STAT, stat(0, 0, 1, 1));
    irq(4'b0001);
    apb(1'b0, `OFF_RXDATA, 32'h0);
    chk("fer data", {24'h0, d1}, {24'h0, rdat[7:0]});
    apb(1'b1, `OFF_STAT, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h0a);
    i_peer.extra_on = 1'b0;
    i_peer.send(d3, 1'b0, 1'b1);
    rchk("plain", `OFF_STAT, stat(1, 0, 0, 0));
    irq(4'b0010);
    apb(1'b1, `OFF_CTRL, 32'h02);
    irq(4'b0000);
    rchk("plain data", `OFF_RXDATA, {24'h0, d3});
    apb(1'b1, `OFF_CTRL, 32'h00);
    rchk("quiet", `OFF_STAT, stat(0, 0, 0, 0));
    apb(1'b1, `OFF_CTRL, 32'h03);
    irq(4'b0000);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
